// >>> logic/accel_operating_mode_control.sv
// operating-mode control: mode register, chain enables, settling, range select output and data gating
`timescale 1ns/100ps
`default_nettype none
module accel_operating_mode_control #(
  parameter int unsigned SETTLE_CYCLES = opmode_pkg::SETTLE_CYCLES,
  parameter int unsigned TEMP_CYCLES = opmode_pkg::TEMP_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // register access from the serial control port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // converter results and events
  input wire logic i_dsm_strobe,
  input wire logic [opmode_pkg::DSM_W-1:0] i_dsm_data,
  input wire logic i_sar_strobe,
  input wire logic [opmode_pkg::SAR_W-1:0] i_sar_data,
  input wire logic [opmode_pkg::TEMP_W-1:0] i_temp_raw,
  input wire logic i_temp_enable,
  input wire logic i_temp_to_fifo,
  input wire logic i_event,
  // chain controls
  output logic o_dsm_enable,
  output logic o_sar_enable,
  output logic o_sensor_on,
  output logic [1:0] o_range,
  output logic o_settled,
  // samples toward output registers and fifo
  output logic o_accel_valid,
  output logic [15:0] o_accel_data,
  output logic o_fifo_write,
  output logic o_temp_valid,
  output logic [opmode_pkg::TEMP_W-1:0] o_temp_data,
  output logic o_irq_event
);
  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic uses_dsm(input logic [3:0] code);
    uses_dsm = code[3] || (code >= opmode_pkg::CODE_HIGH_FIDELITY && code <= opmode_pkg::CODE_LOW_POWER);
  endfunction : uses_dsm

  function automatic logic uses_sar(input logic [3:0] code);
    uses_sar = code[3] || (code >= opmode_pkg::CODE_VERY_LOW_POWER && code <= opmode_pkg::CODE_HEART_SOUND);
  endfunction : uses_sar

  // sar data is left aligned to 16 bits so the sign and the positive direction hold
  function automatic logic [15:0] widen_sar(input logic [opmode_pkg::SAR_W-1:0] v);
    widen_sar = {v, 4'h0};
  endfunction : widen_sar

  typedef struct packed {
    logic [7:0] mode_reg;
    opmode_pkg::phase_t phase;
    logic [31:0] settle_cnt;
    logic [7:0] rdata;
    logic rvalid;
    logic dsm_en;
    logic sar_en;
    logic accel_valid;
    logic [15:0] accel_data;
    logic fifo_write;
    logic irq;
    logic sensor_on;
    logic settled;
    logic temp_valid;
    logic [opmode_pkg::TEMP_W-1:0] temp_data;
  } ctrl_state_t;

  ctrl_state_t s_q;
  ctrl_state_t s_d;

  logic [3:0] mode_code;
  logic measuring;
  logic axis_strobe;
  logic [opmode_pkg::TEMP_W-1:0] temp_val;
  logic temp_strobe;

  assign mode_code = s_q.mode_reg[opmode_pkg::MODE_LSB +: opmode_pkg::MODE_W];
  assign measuring = (s_q.phase != opmode_pkg::ST_STANDBY);
  assign axis_strobe = (s_q.dsm_en && i_dsm_strobe) || (s_q.sar_en && i_sar_strobe);

  // ****************************************
  // temperature channel
  // ****************************************
  temp_sampler #(
    .TEMP_CYCLES(TEMP_CYCLES)
  ) u_temp (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_run(measuring && i_temp_enable),
    .i_axis_strobe(axis_strobe),
    .i_temp_raw(i_temp_raw),
    .o_temp(temp_val),
    .o_temp_strobe(temp_strobe)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.accel_valid = 1'b0;
    s_d.fifo_write = 1'b0;
    s_d.irq = 1'b0;
    // host is expected to write only in standby; the write takes effect at once regardless
    if (i_reg_wr && i_reg_addr == opmode_pkg::MODE_SELECT_ADDR) begin
      s_d.mode_reg = i_reg_wdata; // RULE10 RULE4
    end
    if (i_reg_rd) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = (i_reg_addr == opmode_pkg::MODE_SELECT_ADDR) ? s_q.mode_reg : 8'h00;
    end
    s_d.dsm_en = uses_dsm(mode_code); // RULE1 RULE5
    s_d.sar_en = uses_sar(mode_code); // RULE1 RULE5
    s_d.sensor_on = uses_dsm(mode_code) || uses_sar(mode_code); // RULE3
    s_d.temp_valid = temp_strobe; // RULE8
    s_d.temp_data = temp_val;
    unique case (s_q.phase)
      opmode_pkg::ST_STANDBY: begin
        s_d.settle_cnt = 32'h0000_0000;
        if (mode_code != opmode_pkg::CODE_STANDBY) begin
          s_d.phase = opmode_pkg::ST_SETTLE; // RULE5
        end
      end
      opmode_pkg::ST_SETTLE: begin
        if (mode_code == opmode_pkg::CODE_STANDBY) begin
          s_d.phase = opmode_pkg::ST_STANDBY;
        end else if (s_q.settle_cnt == 32'(SETTLE_CYCLES - 1)) begin
          s_d.phase = opmode_pkg::ST_MEASURE; // RULE6
        end else begin
          s_d.settle_cnt = s_q.settle_cnt + 32'h0000_0001;
        end
      end
      opmode_pkg::ST_MEASURE: begin
        if (mode_code == opmode_pkg::CODE_STANDBY) begin
          s_d.phase = opmode_pkg::ST_STANDBY;
        end
      end
    endcase
    s_d.settled = (s_d.phase == opmode_pkg::ST_MEASURE); // RULE6
    // standby: no samples, no fifo writes, no events
    if (measuring) begin // RULE2
      if (s_q.dsm_en && i_dsm_strobe) begin
        s_d.accel_valid = 1'b1;
        s_d.accel_data = i_dsm_data; // RULE11 RULE7
        s_d.fifo_write = 1'b1;
      end else if (s_q.sar_en && i_sar_strobe) begin
        s_d.accel_valid = 1'b1;
        s_d.accel_data = widen_sar(i_sar_data); // RULE11 RULE7
        s_d.fifo_write = 1'b1;
      end
      // temperature reaches the fifo only while measuring, so standby leaves the fifo alone
      if (temp_strobe && i_temp_to_fifo) begin
        s_d.fifo_write = 1'b1; // RULE8 RULE2
      end
      s_d.irq = i_event;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q <= '0;
      s_q.mode_reg <= opmode_pkg::MODE_SELECT_RESET; // RULE3 RULE12
      s_q.phase <= opmode_pkg::ST_STANDBY; // RULE3
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_reg_rdata = s_q.rdata;
  assign o_reg_rvalid = s_q.rvalid;
  assign o_dsm_enable = s_q.dsm_en;
  assign o_sar_enable = s_q.sar_en;
  assign o_sensor_on = s_q.sensor_on;
  // range travels to the analog scaling directly; code 3 is treated as 16 g there
  assign o_range = s_q.mode_reg[opmode_pkg::RANGE_LSB +: opmode_pkg::RANGE_W]; // RULE7
  assign o_settled = s_q.settled;
  assign o_accel_valid = s_q.accel_valid;
  assign o_accel_data = s_q.accel_data;
  assign o_fifo_write = s_q.fifo_write;
  assign o_temp_valid = s_q.temp_valid;
  assign o_temp_data = s_q.temp_data;
  assign o_irq_event = s_q.irq;

  // ****************************************
  // checks
  // ****************************************
  sequence enter_meas_s;
    s_q.phase == opmode_pkg::ST_STANDBY && mode_code != opmode_pkg::CODE_STANDBY;
  endsequence

  standby_quiet_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $past(s_q.phase) == opmode_pkg::ST_STANDBY && s_q.phase == opmode_pkg::ST_STANDBY
    |-> !o_accel_valid && !o_irq_event && !s_q.fifo_write) else $error("activity in standby"); // RULE2
  settle_start_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    enter_meas_s |=> s_q.phase == opmode_pkg::ST_SETTLE) else $error("settle not started"); // RULE6
  settle_hold_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    enter_meas_s ##1 (mode_code != opmode_pkg::CODE_STANDBY)[*2] |-> !o_settled) else $error("settled too soon"); // RULE6
  chain_dsm_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    ##1 o_dsm_enable == uses_dsm($past(mode_code))) else $error("dsm enable wrong"); // RULE1
  chain_sar_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    ##1 o_sar_enable == uses_sar($past(mode_code))) else $error("sar enable wrong"); // RULE5
  mode_write_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_reg_wr && i_reg_addr == opmode_pkg::MODE_SELECT_ADDR |=> s_q.mode_reg == $past(i_reg_wdata))
    else $error("mode write lost"); // RULE10
  readback_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_reg_rd && i_reg_addr == opmode_pkg::MODE_SELECT_ADDR && !i_reg_wr |=> o_reg_rvalid && o_reg_rdata == s_q.mode_reg)
    else $error("readback wrong"); // RULE12
  range_out_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_reg_wr && i_reg_addr == opmode_pkg::MODE_SELECT_ADDR
    |=> {2'b00, o_range, 4'h0} == ($past(i_reg_wdata) & 8'h30)) else $error("range mismatch"); // RULE7
  dsm_pass_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    measuring && s_q.dsm_en && i_dsm_strobe |=> o_accel_valid && o_accel_data == $past(i_dsm_data))
    else $error("sample altered"); // RULE11
endmodule : accel_operating_mode_control
`default_nettype wire

// >>> logic/temp_sampler.sv
// temperature channel: 100 hz sample timer holding the last reading
`timescale 1ns/100ps
`default_nettype none
module temp_sampler #(
  parameter int unsigned TEMP_CYCLES = opmode_pkg::TEMP_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // control
  input wire logic i_run,
  input wire logic i_axis_strobe,
  input wire logic [opmode_pkg::TEMP_W-1:0] i_temp_raw,
  // result
  output logic [opmode_pkg::TEMP_W-1:0] o_temp,
  output logic o_temp_strobe
);
  typedef struct packed {
    logic [31:0] tick;
    logic [opmode_pkg::TEMP_W-1:0] temp;
    logic strobe;
  } temp_state_t;

  temp_state_t s_q;
  temp_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.strobe = 1'b0;
    if (!i_run) begin
      s_d.tick = 32'h0000_0000;
    end else if (s_q.tick == 32'(TEMP_CYCLES - 1)) begin
      s_d.tick = 32'h0000_0000;
      s_d.temp = i_temp_raw; // RULE9
    end else begin
      s_d.tick = s_q.tick + 32'h0000_0001;
    end
    // while running, the held value is re-issued with every axis sample, fresh or repeated
    if (i_run && i_axis_strobe) begin
      s_d.strobe = 1'b1; // RULE8 RULE9
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_temp = s_q.temp;
  assign o_temp_strobe = s_q.strobe;

  tick_bounded_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    s_q.tick < 32'(TEMP_CYCLES)) else $error("temperature timer overran its period"); // RULE9
endmodule : temp_sampler
`default_nettype wire

// >>> shared/opmode_pkg.sv
// package: register map, mode codes, range codes and timing constants of the operating-mode control
// What this block does
// RULE1 - standby plus six measurement modes, three on the 16-bit delta-sigma chain and three on the 12-bit SAR chain.
// RULE2 - in standby all measurement stops, the FIFO is left untouched and no new interrupt is raised.
// RULE3 - after power-up the block sits in standby with every sensor function off.
// RULE4 - the host changes configuration only in standby, otherwise a change may cover part of a measurement.
// RULE5 - every non-standby mode is measurement, and one delta-sigma plus one SAR mode may run together.
// RULE6 - the host waits 2 ms after entering measurement before reading acceleration data.
// RULE7 - ranges of 4, 8 and 16 g are selectable and sensitivity scales with the range.
// RULE8 - a 12-bit temperature reading is kept, optionally pushed to the FIFO, updating with the axis samples.
// RULE9 - the temperature channel samples at 100 Hz and its last value repeats on faster axis samples.
// RULE10 - the operating mode is taken from the mode-select register at address 0x26.
// RULE11 - each axis output rises when the device accelerates in the positive direction of that axis.
// RULE12 - each mode has its own code, and the register resets to the standby code.
package opmode_pkg;
  localparam logic [7:0] MODE_SELECT_ADDR = 8'h26;
  // mode field bits [3:0], range field bits [5:4]
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 4;
  localparam int RANGE_LSB = 4;
  localparam int RANGE_W = 2;
  localparam logic [7:0] MODE_SELECT_RESET = 8'h00;
  localparam int DSM_W = 16;
  localparam int SAR_W = 12;
  localparam int TEMP_W = 12;

  // mode codes: 0x1..0x6 = single mode, 0x7 enables no chain, codes 0x8..0xF pair one dsm and one sar mode
  localparam logic [3:0] CODE_STANDBY = 4'h0;
  localparam logic [3:0] CODE_HIGH_FIDELITY = 4'h1;
  localparam logic [3:0] CODE_REDUCED_BW = 4'h2;
  localparam logic [3:0] CODE_LOW_POWER = 4'h3;
  localparam logic [3:0] CODE_VERY_LOW_POWER = 4'h4;
  localparam logic [3:0] CODE_ULTRA_LOW_POWER = 4'h5;
  localparam logic [3:0] CODE_HEART_SOUND = 4'h6;

  localparam logic [1:0] RANGE_4G = 2'h0;
  localparam logic [1:0] RANGE_8G = 2'h1;
  localparam logic [1:0] RANGE_16G = 2'h2;

  localparam int CLK_HZ = 100_000_000;
  localparam int SETTLE_MS = 2;
  localparam int SETTLE_CYCLES = CLK_HZ / 1000 * SETTLE_MS;
  localparam int TEMP_ODR_HZ = 100;
  localparam int TEMP_CYCLES = CLK_HZ / TEMP_ODR_HZ;

  typedef enum logic [1:0] {
    ST_STANDBY,
    ST_SETTLE,
    ST_MEASURE
  } phase_t;
endpackage : opmode_pkg

// >>> verif/accel_operating_mode_control_test.sv
// self-checking bench of the operating-mode control
`timescale 1ns/100ps
`default_nettype none
module accel_operating_mode_control_test;
  localparam int SETTLE = 20;
  localparam int TEMP = 50;
  localparam logic [15:0] DSM_VAL = 16'h1234;
  localparam logic [11:0] SAR_VAL = 12'habc;
  logic clk = 1'b0, arst_n = 1'b0, wr, rd, rvalid, dsm_stb = 1'b0, sar_stb = 1'b0;
  logic temp_en = 1'b1, temp_fifo = 1'b1, evt = 1'b0;
  logic dsm_en, sar_en, sensor_on, settled, acc_v, fifo_wr, temp_v, irq;
  logic [7:0] addr, wdata, rdata, rv;
  logic [15:0] dsm_data = 16'h1234, acc_d;
  logic [11:0] sar_data = 12'habc, temp_raw = 12'h155, temp_d;
  logic [1:0] range;
  logic [9:0] rows [9] = '{{8'h00, 2'b00}, {8'h01, 2'b10}, {8'h12, 2'b10}, {8'h23, 2'b10},
    {8'h04, 2'b01}, {8'h15, 2'b01}, {8'h26, 2'b01}, {8'h37, 2'b00}, {8'h29, 2'b11}};
  int n_errors = 0, check_count = 0, cyc = 0;

  always #5 clk = ~clk;

  host_model host (.i_clk(clk), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr),
    .o_reg_wdata(wdata), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid));

  accel_operating_mode_control #(.SETTLE_CYCLES(SETTLE), .TEMP_CYCLES(TEMP)) dut (
    .i_clk(clk), .i_arst_n(arst_n), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_dsm_strobe(dsm_stb),
    .i_dsm_data(dsm_data), .i_sar_strobe(sar_stb), .i_sar_data(sar_data), .i_temp_raw(temp_raw),
    .i_temp_enable(temp_en), .i_temp_to_fifo(temp_fifo), .i_event(evt), .o_dsm_enable(dsm_en),
    .o_sar_enable(sar_en), .o_sensor_on(sensor_on), .o_range(range), .o_settled(settled),
    .o_accel_valid(acc_v), .o_accel_data(acc_d), .o_fifo_write(fifo_wr), .o_temp_valid(temp_v),
    .o_temp_data(temp_d), .o_irq_event(irq));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one-cycle converter strobes; data flips afterwards so late capture shows
  task automatic stb(input logic d, input logic s);
    @(posedge clk) #1;
    dsm_stb = d;
    sar_stb = s;
    dsm_data = DSM_VAL;
    sar_data = SAR_VAL;
    @(posedge clk) #1;
    dsm_stb = 1'b0;
    sar_stb = 1'b0;
    dsm_data = ~DSM_VAL;
    sar_data = ~SAR_VAL;
  endtask : stb

  task automatic event_pulse(input logic exp);
    @(posedge clk) #1;
    evt = 1'b1;
    @(posedge clk) #1;
    evt = 1'b0;
    chk(irq, exp);
  endtask : event_pulse

  task automatic tally_and_finish();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    #1 arst_n = 1'b1;
    chk(sensor_on, 1'b0);
    host.rd(8'h26, rv);
    chk(rv, 8'h00);
    stb(1'b1, 1'b1);
    chk(acc_v, 1'b0);
    event_pulse(1'b0);
    // the six single modes, code 0x7 and the pair code 0x9 are each entered from standby, as the host must
    foreach (rows[i]) begin
      host.wr(8'h26, 8'h00);
      host.wr(8'h26, rows[i][9:2]);
      @(posedge clk) #1;
      chk(dsm_en, rows[i][1]);
      chk(sar_en, rows[i][0]);
      chk(sensor_on, |rows[i][1:0]);
      chk(range, rows[i][7:6]);
      host.rd(8'h26, rv);
      chk(rv, rows[i][9:2]);
    end
    host.wr(8'h27, 8'hff);
    host.rd(8'h27, rv);
    chk(rv, 8'h00);
    host.rd(8'h26, rv);
    chk(rv, 8'h29);
    host.wr(8'h26, 8'h00);
    host.wr(8'h26, 8'h09);
    chk(settled, 1'b0);
    repeat (SETTLE) @(posedge clk);
    #1 chk(settled, 1'b0);
    @(posedge clk) #1;
    chk(settled, 1'b1);
    repeat (TEMP + 10) @(posedge clk);
    stb(1'b1, 1'b0);
    chk(acc_d, 16'h1234);
    chk(fifo_wr, 1'b1);
    @(posedge clk) #1;
    chk(temp_v, 1'b1);
    chk(temp_d, 12'h155);
    chk(fifo_wr, 1'b1);
    temp_raw = 12'h2aa;
    stb(1'b0, 1'b1);
    chk(acc_d, 16'habc0);
    @(posedge clk) #1;
    chk(temp_d, 12'h155);
    repeat (TEMP + 10) @(posedge clk);
    #1 temp_fifo = 1'b0;
    stb(1'b1, 1'b1);
    chk(acc_d, 16'h1234);
    @(posedge clk) #1;
    chk(temp_d, 12'h2aa);
    chk(temp_v, 1'b1);
    chk(fifo_wr, 1'b0);
    temp_en = 1'b0;
    stb(1'b1, 1'b0);
    @(posedge clk) #1;
    chk(temp_v, 1'b0);
    event_pulse(1'b1);
    host.wr(8'h26, 8'h00);
    stb(1'b1, 1'b1);
    chk(acc_v, 1'b0);
    chk(fifo_wr, 1'b0);
    event_pulse(1'b0);
    // reset in mid-run must drop every function back to standby
    host.wr(8'h26, 8'h29);
    @(posedge clk) #1;
    chk(sensor_on, 1'b1);
    arst_n = 1'b0;
    #1 chk(sensor_on, 1'b0);
    chk(settled, 1'b0);
    @(posedge clk) #1;
    arst_n = 1'b1;
    host.rd(8'h26, rv);
    chk(rv, 8'h00);
    tally_and_finish();
  end
endmodule : accel_operating_mode_control_test
`default_nettype wire

// >>> verif/host_model.sv
// host processor model for the mode register port
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // clock
  input wire logic i_clk,
  // register port toward the device
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [7:0] o_reg_addr,
  output logic [7:0] o_reg_wdata,
  input wire logic [7:0] i_reg_rdata,
  input wire logic i_reg_rvalid
);
  initial begin
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 8'h00;
    o_reg_wdata = 8'h00;
  end
  // released lines are inverted so a stale value never looks held
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk) #1;
    o_reg_wr = 1'b1;
    o_reg_addr = a;
    o_reg_wdata = d;
    @(posedge i_clk) #1;
    o_reg_wr = 1'b0;
    o_reg_addr = ~a;
    o_reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge i_clk) #1;
    o_reg_rd = 1'b1;
    o_reg_addr = a;
    @(posedge i_clk) #1;
    o_reg_rd = 1'b0;
    o_reg_addr = ~a;
    n = 0;
    while (i_reg_rvalid !== 1'b1 && n < 4) begin
      @(posedge i_clk) #1;
      n++;
    end
    d = (i_reg_rvalid === 1'b1) ? i_reg_rdata : 8'hxx;
  endtask : rd
endmodule : host_model
`default_nettype wire
